// file: verilog/tvbr_pkg.sv
// Shared constants and carrier types of the tag value block reader
package tvbr_pkg;

    // ------------------------------------------------------------
    // Command and argument layout
    // ------------------------------------------------------------
    localparam logic [7:0] TVBR_CMD_READ_VALUE = 8'h0a;
    localparam int         TVBR_ARG_BYTES      = 9;
    localparam int         TVBR_ARG_BLOCK      = 0;
    localparam int         TVBR_ARG_OFFSET     = 1;
    localparam int         TVBR_ARG_KEY_SEL    = 2;
    localparam int         TVBR_ARG_KEY        = 3;
    localparam int         TVBR_KEY_BYTES      = 6;
    localparam int         TVBR_SEL_USE_KEY    = 6;
    localparam int         TVBR_SEL_KEY_A      = 7;

    // ------------------------------------------------------------
    // Value block layout and buffer image
    // ------------------------------------------------------------
    localparam int         TVBR_BLOCK_BYTES    = 16;
    localparam int         TVBR_VALUE_BYTES    = 4;
    localparam int         TVBR_ADDR_POS       = 12;
    localparam int         TVBR_OUT_BYTES      = 5;
    localparam logic [2:0] TVBR_OUT_LAST       = 3'h4;

    // ------------------------------------------------------------
    // Outcome codes
    // ------------------------------------------------------------
    localparam logic [1:0] TVBR_RES_OK         = 2'h0;
    localparam logic [1:0] TVBR_RES_BAD_CMD    = 2'h1;
    localparam logic [1:0] TVBR_RES_TAG_FAIL   = 2'h2;
    localparam logic [1:0] TVBR_RES_NOT_VALUE  = 2'h3;

    typedef logic [TVBR_ARG_BYTES-1:0][7:0]   tvbr_args_t;
    typedef logic [TVBR_BLOCK_BYTES-1:0][7:0] tvbr_block_t;

    // Request to the radio side: authenticate and read one block
    typedef struct packed {
        logic [7:0]  block;
        logic [7:0]  key_sel;
        logic        use_key;
        logic        key_a;
        logic [47:0] key;
    } tvbr_tag_req_t;

    // Byte write into the data buffer
    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] data;
    } tvbr_buf_wr_t;

endpackage : tvbr_pkg

// file: verilog/tvbr_reader.sv
// Read value command handler: tag access, value decode, buffer write
//
// Behaviour
// - Command code 0x0a starts the value read with block, offset, key selector and optional key.
// - The block argument is passed on as a zero-based absolute block index, never a byte address.
// - The key bytes are used only when selector bit 6 is set and ignored otherwise.
// - An explicit key authenticates as key A when selector bit 7 is set, else as key B.
// - The six key bytes are taken least significant first from the lowest argument position.
// - The tag access, authentication included, is the same one the plain block read performs.
// - The block is decoded into a signed 4-byte value from its first four bytes and the address byte from byte 12.
// - On success the value goes at the buffer offset and the address byte right after it.
// - The value is written two's complement, least significant byte first, address as one byte.
`timescale 1ns/1ps
`default_nettype none

module tvbr_reader
    import tvbr_pkg::*;
#(
    parameter int BUF_BYTES = 256
) (
    input  wire logic          mclk,
    input  wire logic          reset_n,
    input  wire logic          cmd_start,
    input  wire logic [7:0]    cmd_code,
    input  wire tvbr_args_t    cmd_args,
    output tvbr_tag_req_t      tag_req,
    output logic               tag_req_valid,
    input  wire logic          tag_ack,
    input  wire logic          tag_ok,
    input  wire tvbr_block_t   tag_data,
    output tvbr_buf_wr_t       buf_wr,
    output logic               busy,
    output logic               done,
    output logic [1:0]         result
);

    typedef enum logic [2:0] {
        TVBR_IDLE,
        TVBR_ACCESS,
        TVBR_WRITE,
        TVBR_FINISH
    } tvbr_state_t;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Value block: value, inverted value, value, then addr/~addr/addr/~addr
    function automatic logic tvbr_is_value(input tvbr_block_t b);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < TVBR_VALUE_BYTES; i++) begin
            if (b[i] != b[i+8] || b[i] != ~b[i+4])
                ok = 1'b0;
        end
        if (b[TVBR_ADDR_POS] != b[TVBR_ADDR_POS+2] ||
            b[TVBR_ADDR_POS] != ~b[TVBR_ADDR_POS+1] ||
            b[TVBR_ADDR_POS] != ~b[TVBR_ADDR_POS+3])
            ok = 1'b0;
        return ok;
    endfunction : tvbr_is_value

    tvbr_state_t     state_q, state_d;
    tvbr_tag_req_t   req_q;
    logic            req_valid_q;
    logic [7:0]      offset_q;
    logic [7:0][7:0] image_q;
    logic [2:0]      idx_q;
    tvbr_buf_wr_t    wr_q;
    logic            busy_q;
    logic            done_q;
    logic [1:0]      result_q;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire logic       start_ok;
    wire logic       fits;
    wire logic [8:0] end_addr;
    wire logic       is_value;
    wire logic       last_byte;
    wire logic [7:0] sel_byte;

    assign start_ok  = cmd_start && (cmd_code == TVBR_CMD_READ_VALUE);
    assign end_addr  = {1'b0, cmd_args[TVBR_ARG_OFFSET]}
                     + 9'(TVBR_OUT_BYTES);
    // Image must not run past the end of the buffer
    assign fits      = end_addr <= 9'(BUF_BYTES);
    // Check block format before anything is written
    assign is_value  = tvbr_is_value(tag_data);
    assign last_byte = idx_q == TVBR_OUT_LAST;
    assign sel_byte  = cmd_args[TVBR_ARG_KEY_SEL];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            TVBR_IDLE: begin
                if (cmd_start)
                    state_d = (start_ok && fits) ? TVBR_ACCESS
                                                 : TVBR_FINISH;
            end
            TVBR_ACCESS: begin
                if (tag_ack)
                    state_d = (tag_ok && is_value) ? TVBR_WRITE
                                                   : TVBR_FINISH;
            end
            TVBR_WRITE: begin
                if (last_byte)
                    state_d = TVBR_FINISH;
            end
            TVBR_FINISH: begin
                state_d = TVBR_IDLE;
            end
            default: begin
                state_d = TVBR_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            state_q <= TVBR_IDLE;
        else
            state_q <= state_d;
    end

    // ------------------------------------------------------------
    // Tag request
    // ------------------------------------------------------------
    // Request is held until the radio side acknowledges it
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            req_q       <= '0;
            req_valid_q <= 1'b0;
            offset_q    <= 8'h00;
        end else if (state_q == TVBR_IDLE && start_ok && fits) begin
            // Absolute block index passed on unchanged
            req_q.block   <= cmd_args[TVBR_ARG_BLOCK];
            req_q.key_sel <= sel_byte;
            // Explicit key only on bit 6
            req_q.use_key <= sel_byte[TVBR_SEL_USE_KEY];
            req_q.key_a   <= sel_byte[TVBR_SEL_KEY_A];
            // Lowest argument byte is key bit 7:0
            req_q.key     <= sel_byte[TVBR_SEL_USE_KEY]
                ? cmd_args[TVBR_ARG_KEY+TVBR_KEY_BYTES-1:TVBR_ARG_KEY]
                : 48'h0;
            req_valid_q   <= 1'b1;
            offset_q      <= cmd_args[TVBR_ARG_OFFSET];
        end else if (state_q == TVBR_ACCESS && tag_ack) begin
            req_valid_q   <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Buffer image and writer
    // ------------------------------------------------------------
    // Block fetched by the shared authenticate-and-read access
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            image_q <= '0;
        end else if (state_q == TVBR_ACCESS && tag_ack) begin
            // Value bytes keep their LSB-first order
            image_q[3:0] <= tag_data[TVBR_VALUE_BYTES-1:0];
            image_q[4]   <= tag_data[TVBR_ADDR_POS];
            image_q[7:5] <= '0;
        end
    end

    // Writes happen only in the write state, after all checks
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            idx_q <= 3'h0;
            wr_q  <= '0;
        end else if (state_q == TVBR_WRITE) begin
            idx_q   <= idx_q + 3'h1;
            wr_q.we   <= 1'b1;
            wr_q.addr <= offset_q + {5'h00, idx_q};
            wr_q.data <= image_q[idx_q];
        end else begin
            idx_q   <= 3'h0;
            wr_q.we <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q   <= 1'b0;
            done_q   <= 1'b0;
            result_q <= TVBR_RES_OK;
        end else begin
            busy_q <= state_d != TVBR_IDLE;
            done_q <= state_q == TVBR_FINISH;
            if (state_q == TVBR_IDLE && cmd_start) begin
                // Refused commands report an error outcome
                if (!start_ok || !fits)
                    result_q <= TVBR_RES_BAD_CMD;
                else
                    result_q <= TVBR_RES_OK;
            end else if (state_q == TVBR_ACCESS && tag_ack) begin
                if (!tag_ok)
                    result_q <= TVBR_RES_TAG_FAIL;
                else if (!is_value)
                    result_q <= TVBR_RES_NOT_VALUE;
            end
        end
    end

    assign tag_req       = req_q;
    assign tag_req_valid = req_valid_q;
    assign buf_wr        = wr_q;
    assign busy          = busy_q;
    assign done          = done_q;
    assign result        = result_q;

endmodule : tvbr_reader

`default_nettype wire

// file: verif/tvbr_reader_checker.sv
// Assertions on the ports of the value read command handler
`timescale 1ns/1ps
`default_nettype none
module tvbr_reader_checker
    import tvbr_pkg::*;
(
    input wire logic          mclk,
    input wire logic          reset_n,
    input wire logic          cmd_start,
    input wire logic [7:0]    cmd_code,
    input wire tvbr_args_t    cmd_args,
    input wire tvbr_tag_req_t tag_req,
    input wire logic          tag_req_valid,
    input wire logic          tag_ack,
    input wire logic          tag_ok,
    input wire tvbr_buf_wr_t  buf_wr,
    input wire logic          busy,
    input wire logic          done,
    input wire logic [1:0]    result
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    a_start_busy: assert property (cmd_start && !busy |=> busy)
        else $error("busy did not follow an accepted start");
    a_bad_code: assert property (cmd_start && !busy
        && cmd_code != 8'h0a |=> !tag_req_valid ##1
        (done && result == TVBR_RES_BAD_CMD))
        else $error("foreign code not refused in time");
    a_req_args: assert property ($rose(tag_req_valid)
        |-> tag_req.block == $past(cmd_args[TVBR_ARG_BLOCK]) &&
        tag_req.key_sel == $past(cmd_args[TVBR_ARG_KEY_SEL]))
        else $error("tag request does not carry the arguments");
    a_use_key: assert property (tag_req_valid
        |-> tag_req.use_key == tag_req.key_sel[TVBR_SEL_USE_KEY])
        else $error("use_key differs from selector bit");
    a_key_zero: assert property (tag_req_valid && !tag_req.use_key
        |-> tag_req.key == 48'h0)
        else $error("key bytes passed on without selector bit");
    a_key_kind: assert property (tag_req_valid
        |-> tag_req.key_a == tag_req.key_sel[TVBR_SEL_KEY_A])
        else $error("key kind differs from selector bit");
    a_key_order: assert property ($rose(tag_req_valid)
        && tag_req.use_key |-> tag_req.key ==
        $past(cmd_args[TVBR_ARG_KEY+TVBR_KEY_BYTES-1:TVBR_ARG_KEY]))
        else $error("key bytes not taken lowest first");
    a_req_stable: assert property (tag_req_valid
        && $past(tag_req_valid) |-> $stable(tag_req))
        else $error("tag request moved while outstanding");
    a_write_run: assert property ($rose(buf_wr.we)
        |-> buf_wr.we [*5] ##1 (!buf_wr.we && done))
        else $error("buffer write run is not five bytes");
    a_addr_step: assert property (buf_wr.we && $past(buf_wr.we)
        |-> buf_wr.addr == $past(buf_wr.addr) + 8'h01)
        else $error("buffer address did not step by one");
    a_fail_nowr: assert property (tag_req_valid && tag_ack && !tag_ok
        |=> !buf_wr.we ##1 (done && result == TVBR_RES_TAG_FAIL))
        else $error("tag failure not reported cleanly");
    cover property (done && result == TVBR_RES_OK);
    cover property (done && result == TVBR_RES_TAG_FAIL);
    cover property (done && result == TVBR_RES_NOT_VALUE);
endmodule : tvbr_reader_checker
bind tvbr_reader tvbr_reader_checker u_chk (.mclk(mclk), .reset_n(reset_n),
    .cmd_start(cmd_start), .cmd_code(cmd_code), .cmd_args(cmd_args),
    .tag_req(tag_req),
    .tag_req_valid(tag_req_valid), .tag_ack(tag_ack), .tag_ok(tag_ok),
    .buf_wr(buf_wr), .busy(busy), .done(done), .result(result));
`default_nettype wire

// file: verif/tvbr_tag_model.sv
// Behavioural tag: authenticates, returns value blocks
`timescale 1ns/1ps
`default_nettype none
module tvbr_tag_model
    import tvbr_pkg::*;
(
    input  wire logic          mclk,
    input  wire tvbr_tag_req_t tag_req,
    input  wire logic          tag_req_valid,
    input  wire logic [3:0]    wait_cyc,
    input  wire logic          bad_fmt,
    output logic               tag_ack,
    output logic               tag_ok,
    output tvbr_block_t        tag_data
);
    logic [31:0] v;
    logic [7:0]  a;
    initial begin
        tag_ack = 1'b0;
        tag_ok = 1'b0;
        tag_data = '0;
        forever begin
            @(negedge mclk);
            if (tag_req_valid) begin
                repeat (wait_cyc) @(negedge mclk);
                v = {tag_req.block, 8'hc3, ~tag_req.block, 8'h81};
                a = tag_req.block ^ 8'h55;
                tag_ok = !tag_req.use_key || tag_req.key ==
                    (tag_req.key_a ? 48'h060504030201 : 48'h0c0b0a090807);
                tag_data = {~a, a, ~a, a, v, ~v ^ {31'h0, bad_fmt}, v};
                tag_ack = 1'b1;
                @(negedge mclk);
                // Released lines show garbage, not the last value
                tag_ack = 1'b0;
                tag_ok = ~tag_ok;
                tag_data = ~tag_data;
            end
        end
    end
endmodule : tvbr_tag_model
`default_nettype wire

// file: verif/tvbr_reader_bench.sv
// Self-checking bench of the value read command handler
`timescale 1ns/1ps
`default_nettype none
module tvbr_reader_bench;
    import tvbr_pkg::*;
    localparam logic [47:0] KA = 48'h060504030201;
    logic mclk = 1'b0, reset_n = 1'b0, cmd_start = 1'b0, bad_fmt = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic [3:0] wait_cyc = 4'h0;
    tvbr_args_t cmd_args = '0;
    tvbr_tag_req_t tag_req;
    tvbr_block_t tag_data;
    tvbr_buf_wr_t buf_wr;
    logic tag_req_valid, tag_ack, tag_ok, busy, done;
    logic [1:0] result;
    logic [7:0] mem [256];
    int err_total = 0, comparisons = 0, wr_cnt = 0;
    always #2.5 mclk = ~mclk;
    tvbr_reader u_dut (.mclk(mclk), .reset_n(reset_n), .cmd_start(cmd_start),
        .cmd_code(cmd_code), .cmd_args(cmd_args), .tag_req(tag_req),
        .tag_req_valid(tag_req_valid), .tag_ack(tag_ack), .tag_ok(tag_ok),
        .tag_data(tag_data), .buf_wr(buf_wr), .busy(busy), .done(done),
        .result(result));
    tvbr_tag_model u_tag (.mclk(mclk), .tag_req(tag_req),
        .tag_req_valid(tag_req_valid), .wait_cyc(wait_cyc), .bad_fmt(bad_fmt),
        .tag_ack(tag_ack), .tag_ok(tag_ok), .tag_data(tag_data));
    // Buffer image kept by the bench
    always @(negedge mclk) if (buf_wr.we === 1'b1) begin
        mem[buf_wr.addr] = buf_wr.data;
        wr_cnt++;
    end
    task automatic check(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic do_read(input logic [7:0] code, blk, off, sel,
                           input logic [47:0] key, input int res);
        int n;
        n = 0;
        wr_cnt = 0;
        cmd_code = code;
        cmd_args = {key, sel, off, blk}; // argument bytes 0 to 8
        cmd_start = 1'b1;
        @(negedge mclk);
        cmd_start = 1'b0;
        check(busy, 1'b1); // command taken
        while (done !== 1'b1 && n < 60) begin
            @(negedge mclk);
            n++;
        end
        check(done, 1'b1); // command ends
        check(busy, 1'b0); // idle at done
        check(result, res); // outcome code
        if (res === TVBR_RES_OK) begin
            check({mem[off + 8'h3], mem[off + 8'h2], mem[off + 8'h1], mem[off]},
                  {blk, 8'hc3, ~blk, 8'h81}); // LSB first
            check(mem[off + 8'h4], blk ^ 8'h55); // address byte
        end
        check(wr_cnt, res === TVBR_RES_OK ? 5 : 0); // all or none
    endtask : do_read
    task automatic t_plain();
        do_read(8'h0a, 8'h09, 8'h00, 8'h00, 48'hffffffffffff, 0);
        do_read(8'h0a, 8'h83, 8'hfb, 8'h80, 48'h0, 0); // top end
        do_read(8'h0a, 8'h10, 8'hfc, 8'h00, 48'h0, 1); // past buffer end
        $display("test plain done");
    endtask : t_plain
    task automatic t_keys();
        wait_cyc = 4'h3;
        do_read(8'h0a, 8'h21, 8'h20, 8'hc0, KA, 0); // key A
        do_read(8'h0a, 8'h22, 8'h28, 8'h40, KA, 2); // key B refused
        do_read(8'h0a, 8'h23, 8'h30, 8'h40, 48'h0c0b0a090807, 0);
        do_read(8'h0a, 8'h24, 8'h38, 8'hc0, 48'h010203040506, 2);
        $display("test keys done");
    endtask : t_keys
    task automatic t_errs();
        do_read(8'h0b, 8'h09, 8'h40, 8'h00, 48'h0, 1); // foreign code
        bad_fmt = 1'b1;
        wait_cyc = 4'hc;
        do_read(8'h0a, 8'h05, 8'h48, 8'h00, 48'h0, 3); // no value
        bad_fmt = 1'b0;
        $display("test errors done");
    endtask : t_errs
    task automatic final_report();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    initial begin
        #20000;
        err_total++;
        final_report();
    end
    initial begin
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        t_plain();
        t_keys();
        t_errs();
        final_report();
    end
endmodule : tvbr_reader_bench
`default_nettype wire
